// *** mdrc_pkg.sv ***
/*
  Shared constants and types for the multi-domain reset controller.
  Assumes a 32-bit APB with byte addresses in paddr[7:0].
*/
package mdrc_pkg;
  localparam int NFUNC = 5;
  localparam int AW = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_SUBSYS = 8'h00;
  localparam logic [7:0] OFF_BRCFG = 8'h04;
  localparam logic [7:0] OFF_MISC4 = 8'h08;
  localparam logic [7:0] OFF_SROM = 8'h0C;
  localparam logic [7:0] OFF_GUIDH = 8'h10;
  localparam logic [7:0] OFF_GUIDL = 8'h14;
  localparam logic [7:0] OFF_STKCLK = 8'h18;
  localparam logic [7:0] OFF_SDCD = 8'h1C;
  localparam logic [7:0] OFF_SEVT = 8'h20;
  localparam logic [7:0] OFF_SMASK = 8'h24;
  localparam logic [7:0] OFF_SPRES = 8'h28;
  localparam logic [7:0] OFF_SCTL = 8'h2C;
  localparam logic [7:0] OFF_PWRCTL = 8'h30;
  localparam logic [7:0] OFF_CSC = 8'h34;
  localparam logic [7:0] OFF_CSCCFG = 8'h38;
  localparam logic [7:0] OFF_PM0 = 8'h40;
  localparam logic [7:0] OFF_STAT = 8'h5C;
  localparam logic [7:0] OFF_ORD0 = 8'h60;

  // Writable field masks
  localparam logic [31:0] MSK_SROM = 32'h0000_00FF;
  localparam logic [31:0] MSK_24 = 32'h00FF_FFFF;
  localparam logic [31:0] MSK_SPRES = 32'h0000_0C30;

  // Field positions
  localparam int PM_EN_BIT = 8;
  localparam int PM_STS_BIT = 15;
  localparam int PMC_BIT = 31;
  localparam int ST_ARMED_LSB = 8;
  localparam int ST_SIRQ_BIT = 16;

  // Power states and serial interrupt stop-pulse widths
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3 = 2'h3;
  localparam logic [1:0] STOP_QUIET = 2'h2;
  localparam logic [1:0] STOP_CONT = 2'h3;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [1:0] RST_PS = 2'h0;
  localparam logic RST_SIRQ_CONT = 1'b1;
  localparam logic RST_SYNC = 1'b0;

  typedef struct packed {
    logic global_reset_n;
    logic host_bus_reset_n;
    logic hw_suspend_n;
  } mdrc_pins_t;

  typedef struct packed {
    logic [3:0] sock_evt_set;
    logic [3:0] csc_set;
    logic [NFUNC-1:0] pme_set;
    logic stop_valid;
    logic [1:0] stop_width;
  } mdrc_evt_t;

  typedef struct packed {
    logic sirq_continuous;
    logic [NFUNC-1:0] wake_armed;
    logic global_reset_active;
    logic bus_reset_active;
  } mdrc_stat_t;

  typedef struct packed {
    logic [31:0] subsys, brcfg, misc4;
    logic [7:0] srom;
    logic [31:0] guid_hi, guid_lo;
    logic [23:0] stk_clk, sd_cd;
    logic [3:0] sock_evt, sock_mask, sock_pres;
    logic [2:0] sock_ctl;
    logic [5:0] pwr_ctl;
    logic [3:0] csc, csc_cfg;
    logic [NFUNC-1:0][1:0] pm_state;
    logic [NFUNC-1:0] pme_en, pme_sts, pmc_d3c;
    logic [NFUNC-1:0][31:0] ord;
    logic sirq_cont;
    logic [31:0] rdata;
  } mdrc_regs_t;

  typedef struct packed {
    logic [NFUNC-1:0] armed_hold;
  } mdrc_cls_t;
endpackage

// *** mdrc_sync.sv ***
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes the inputs are asynchronous levels; clears to zero, i.e. resets asserted.
*/
`timescale 1ns/10ps
module mdrc_sync #(parameter int W = 3) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mdrc_sync_st_t;

  mdrc_sync_st_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule // mdrc_sync

// *** mdrc_rst_class.sv ***
/*
  Reset-class decoder: turns global reset, bus reset and D3 exits into clears.
  Assumes all inputs are synchronous to pclk.
*/
`timescale 1ns/10ps
module mdrc_rst_class
  import mdrc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Reset sources
  input wire logic glob_rst,
  input wire logic bus_rst,
  input wire logic [mdrc_pkg::NFUNC-1:0] armed_now,
  input wire logic [mdrc_pkg::NFUNC-1:0] d3_exit,
  // Clears per class
  output logic clr_res,
  output logic [mdrc_pkg::NFUNC-1:0] clr_wake,
  output logic [mdrc_pkg::NFUNC-1:0] clr_ord,
  output logic [mdrc_pkg::NFUNC-1:0] armed_eff
);
  mdrc_cls_t st_ff, nxt_st;

  // The bus reset clears the power state, so the arming seen at its onset is held
  always_comb begin
    nxt_st = st_ff;
    if (ce && !bus_rst) begin
      nxt_st.armed_hold = armed_now;
    end
    if (ce && glob_rst) begin
      nxt_st.armed_hold = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign armed_eff = bus_rst ? st_ff.armed_hold : armed_now; // [R7]
  assign clr_res = glob_rst; // [R3] [R15]
  assign clr_wake = {NFUNC{glob_rst}} | ({NFUNC{bus_rst}} & ~armed_eff); // [R2] [R7] [R15]
  assign clr_ord = {NFUNC{glob_rst | bus_rst}} | d3_exit; // [R2] [R10] [R15]
endmodule // mdrc_rst_class

// *** mdrc_top.sv ***
/*
  Multi-domain reset controller with an APB register file.
  Assumes APB on pclk; reset and suspend pins are asynchronous levels.
*/
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
// What this block does
// R1: Global reset returns all state and every register to defaults.
// R2: Bus reset clears all except resistant and armed wake-context registers.
// R3: Bridge identity, config, misc, timing, serial ROM cleared by global only.
// R4: Link unique identifier high and low survive bus reset.
// R5: Stick reader clock control survives bus reset.
// R6: SD card-detect control survives bus reset.
// R7: Wake context kept through bus reset when in D3 with wake enable set.
// R8: Wake context holds socket event, mask, state, control, power, status change.
// R9: Wake context holds each function's wake capability, enable and status bits.
// R10: D3 to D0 clears all but resistant, wake-context and global registers.
// R11: Platform powers rails, then releases global, suspend, bus reset in order.
// R12: Platform runs host bus clock 100 us before releasing bus reset.
// R13: Platform may release global reset before host bus rail powers.
// R14: After global reset, serial interrupt start frame is continuous mode.
// R15: Each register has a reset class decoded from resets and power state.
module mdrc_top
  import mdrc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mdrc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset and suspend pins
  input wire mdrc_pkg::mdrc_pins_t pins,
  // Hardware events
  input wire mdrc_pkg::mdrc_evt_t evt,
  // Status
  output mdrc_pkg::mdrc_stat_t stat
);
  import mdrc_pkg::*;

  mdrc_regs_t st_ff, nxt_st;
  mdrc_pins_t pins_s;
  logic glob_rst, bus_rst, suspended;
  logic clr_res;
  logic [NFUNC-1:0] clr_wake, clr_ord, armed_now, armed_eff, d3_exit;
  logic wr_en, rd_setup;

  // Per-function words sit one word apart from their base offset
  function automatic logic [AW-1:0] slot_addr(input logic [AW-1:0] base, input int f);
    return base + AW'(4 * f);
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      OFF_SUBSYS, OFF_BRCFG, OFF_MISC4, OFF_SROM, OFF_GUIDH, OFF_GUIDL,
      OFF_STKCLK, OFF_SDCD, OFF_SEVT, OFF_SMASK, OFF_SPRES, OFF_SCTL,
      OFF_PWRCTL, OFF_CSC, OFF_CSCCFG, OFF_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    for (int f = 0; f < NFUNC; f++) begin
      if (a == slot_addr(OFF_PM0, f) || a == slot_addr(OFF_ORD0, f)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] pres_word(input logic [3:0] p);
    return {20'h0_0000, p[3:2], 4'h0, p[1:0], 4'h0};
  endfunction

  function automatic logic [31:0] pm_word(input mdrc_regs_t r, input int f);
    logic [31:0] w;
    w = RST_WORD;
    w[1:0] = r.pm_state[f];
    w[PM_EN_BIT] = r.pme_en[f];
    w[PM_STS_BIT] = r.pme_sts[f];
    w[PMC_BIT] = r.pmc_d3c[f];
    return w;
  endfunction

  function automatic logic [31:0] rd_word(input logic [AW-1:0] a, input mdrc_regs_t r,
                                          input mdrc_pins_t p, input logic [NFUNC-1:0] arm);
    logic [31:0] w;
    w = RST_WORD;
    case (a)
      OFF_SUBSYS: w = r.subsys;
      OFF_BRCFG: w = r.brcfg;
      OFF_MISC4: w = r.misc4;
      OFF_SROM: w = {24'h00_0000, r.srom};
      OFF_GUIDH: w = r.guid_hi;
      OFF_GUIDL: w = r.guid_lo;
      OFF_STKCLK: w = {8'h00, r.stk_clk};
      OFF_SDCD: w = {8'h00, r.sd_cd};
      OFF_SEVT: w = {28'h000_0000, r.sock_evt};
      OFF_SMASK: w = {28'h000_0000, r.sock_mask};
      OFF_SPRES: w = pres_word(r.sock_pres);
      OFF_SCTL: w = {25'h000_0000, r.sock_ctl, 4'h0};
      OFF_PWRCTL: w = {24'h00_0000, r.pwr_ctl, 2'h0};
      OFF_CSC: w = {28'h000_0000, r.csc};
      OFF_CSCCFG: w = {28'h000_0000, r.csc_cfg};
      OFF_STAT: begin
        w[2:0] = {p.hw_suspend_n, p.host_bus_reset_n, p.global_reset_n};
        w[ST_ARMED_LSB +: NFUNC] = arm;
        w[ST_SIRQ_BIT] = r.sirq_cont;
      end
      default: w = RST_WORD;
    endcase
    for (int f = 0; f < NFUNC; f++) begin
      if (a == slot_addr(OFF_PM0, f)) begin
        w = pm_word(r, f);
      end
      if (a == slot_addr(OFF_ORD0, f)) begin
        w = r.ord[f];
      end
    end
    return w;
  endfunction

  // Resistant class: only the global reset reaches it
  function automatic mdrc_regs_t clr_resistant(input mdrc_regs_t r);
    mdrc_regs_t o;
    o = r;
    o.subsys = RST_WORD; // [R3]
    o.brcfg = RST_WORD; // [R3]
    o.misc4 = RST_WORD; // [R3]
    o.srom = MSK_SROM[7:0] & RST_WORD[7:0]; // [R3]
    o.guid_hi = RST_WORD; // [R4]
    o.guid_lo = RST_WORD; // [R4]
    o.stk_clk = MSK_24[23:0] & RST_WORD[23:0]; // [R5]
    o.sd_cd = MSK_24[23:0] & RST_WORD[23:0]; // [R6]
    o.sirq_cont = RST_SIRQ_CONT; // [R1] [R14]
    return o;
  endfunction

  // Socket wake context belongs to the bridge function
  function automatic mdrc_regs_t clr_socket(input mdrc_regs_t r);
    mdrc_regs_t o;
    o = r;
    o.sock_evt = RST_NIB; // [R8]
    o.sock_mask = RST_NIB; // [R8]
    o.sock_pres = RST_NIB; // [R8]
    o.sock_ctl = RST_NIB[2:0]; // [R8]
    o.pwr_ctl = MSK_SPRES[5:0] & RST_WORD[5:0]; // [R8]
    o.csc = RST_NIB; // [R8]
    o.csc_cfg = RST_NIB; // [R8]
    return o;
  endfunction

  // Wake capability, enable and status of one function
  function automatic mdrc_regs_t clr_pm_wake(input mdrc_regs_t r, input int f);
    mdrc_regs_t o;
    o = r;
    o.pme_en[f] = 1'b0; // [R9]
    o.pme_sts[f] = 1'b0; // [R9]
    o.pmc_d3c[f] = 1'b0; // [R9]
    return o;
  endfunction

  // Pins cross into pclk before any decode
  mdrc_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(pins),
    .q(pins_s)
  );

  assign glob_rst = ~pins_s.global_reset_n;
  assign bus_rst = ~pins_s.host_bus_reset_n;
  assign suspended = ~pins_s.hw_suspend_n;

  // A function is armed only while parked in D3 with its wake enable set
  always_comb begin
    for (int f = 0; f < NFUNC; f++) begin
      armed_now[f] = (st_ff.pm_state[f] == PS_D3) && st_ff.pme_en[f]; // [R7]
    end
  end

  // Suspend disables the bus side: writes are refused, reads still answer
  assign wr_en = ce && psel && penable && pwrite && is_mapped(paddr) && !suspended;
  assign rd_setup = ce && psel && !penable && !pwrite;

  // Only a write that leaves D3 for D0 counts; other state moves keep scratch
  always_comb begin
    for (int f = 0; f < NFUNC; f++) begin
      d3_exit[f] = wr_en && paddr == slot_addr(OFF_PM0, f) && st_ff.pm_state[f] == PS_D3
                   && pwdata[1:0] == PS_D0; // [R10]
    end
  end

  mdrc_rst_class u_cls (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .glob_rst(glob_rst),
    .bus_rst(bus_rst),
    .armed_now(armed_now),
    .d3_exit(d3_exit),
    .clr_res(clr_res),
    .clr_wake(clr_wake),
    .clr_ord(clr_ord),
    .armed_eff(armed_eff)
  );

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      if (rd_setup) begin
        nxt_st.rdata = rd_word(paddr, st_ff, pins_s, armed_eff);
      end
      if (wr_en) begin
        case (paddr)
          OFF_SUBSYS: nxt_st.subsys = pwdata;
          OFF_BRCFG: nxt_st.brcfg = pwdata;
          OFF_MISC4: nxt_st.misc4 = pwdata;
          OFF_SROM: nxt_st.srom = pwdata[7:0];
          OFF_GUIDH: nxt_st.guid_hi = pwdata;
          OFF_GUIDL: nxt_st.guid_lo = pwdata;
          OFF_STKCLK: nxt_st.stk_clk = pwdata[23:0];
          OFF_SDCD: nxt_st.sd_cd = pwdata[23:0];
          OFF_SEVT: nxt_st.sock_evt = st_ff.sock_evt & ~pwdata[3:0];
          OFF_SMASK: nxt_st.sock_mask = pwdata[3:0];
          OFF_SPRES: nxt_st.sock_pres = {pwdata[11:10], pwdata[5:4]};
          OFF_SCTL: nxt_st.sock_ctl = pwdata[6:4];
          OFF_PWRCTL: nxt_st.pwr_ctl = pwdata[7:2];
          OFF_CSC: nxt_st.csc = st_ff.csc & ~pwdata[3:0];
          OFF_CSCCFG: nxt_st.csc_cfg = pwdata[3:0];
          default: nxt_st.srom = nxt_st.srom;
        endcase
        for (int f = 0; f < NFUNC; f++) begin
          if (paddr == slot_addr(OFF_PM0, f)) begin
            nxt_st.pm_state[f] = pwdata[1:0];
            nxt_st.pme_en[f] = pwdata[PM_EN_BIT];
            nxt_st.pmc_d3c[f] = pwdata[PMC_BIT];
            if (pwdata[PM_STS_BIT]) begin
              nxt_st.pme_sts[f] = 1'b0;
            end
          end
          if (paddr == slot_addr(OFF_ORD0, f)) begin
            nxt_st.ord[f] = pwdata;
          end
        end
      end
      // Hardware sets land after software clears so a same-cycle event survives
      nxt_st.sock_evt = nxt_st.sock_evt | evt.sock_evt_set;
      nxt_st.csc = nxt_st.csc | evt.csc_set;
      nxt_st.pme_sts = nxt_st.pme_sts | evt.pme_set;
      // Stop pulse width picks the next start-frame mode
      if (evt.stop_valid && evt.stop_width == STOP_QUIET) begin
        nxt_st.sirq_cont = 1'b0;
      end else if (evt.stop_valid && evt.stop_width == STOP_CONT) begin
        nxt_st.sirq_cont = 1'b1;
      end
      // Reset clears land last so they outrank same-cycle writes and events
      if (clr_res) begin
        nxt_st = clr_resistant(nxt_st); // [R3]
      end
      if (clr_wake[0]) begin
        nxt_st = clr_socket(nxt_st); // [R8]
      end
      // Bus reset returns the power state to D0 once the arming is latched
      for (int f = 0; f < NFUNC; f++) begin
        if (clr_wake[f]) begin
          nxt_st = clr_pm_wake(nxt_st, f); // [R9]
        end
        if (clr_ord[f]) begin
          nxt_st.ord[f] = RST_WORD; // [R2] [R10]
        end
        if (clr_ord[f] && !d3_exit[f]) begin
          nxt_st.pm_state[f] = RST_PS; // [R1] [R2]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.sirq_cont <= RST_SIRQ_CONT; // [R1] [R14]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero-wait slave: read data was captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!is_mapped(paddr) || (pwrite && suspended));
  assign prdata = st_ff.rdata;

  assign stat.sirq_continuous = st_ff.sirq_cont;
  assign stat.wake_armed = armed_eff;
  assign stat.global_reset_active = glob_rst;
  assign stat.bus_reset_active = bus_rst;
endmodule // mdrc_top

// *** mdrc_assertions.sv ***
/*
  Port-level checker for mdrc_top, bound to every instance.
  Assumes pins and events change just after pclk edges.
*/
`timescale 1ns/10ps
module mdrc_chk
  import mdrc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mdrc_pkg::AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and status
  input wire mdrc_pkg::mdrc_pins_t pins,
  input wire mdrc_pkg::mdrc_stat_t stat
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite && ce && paddr[1:0] == 2'h0;
  property p_gbl_flag;
    (!pins.global_reset_n && ce) [*3] |-> stat.global_reset_active;
  endproperty
  a_gbl_flag: assert property (p_gbl_flag) else $error("global reset flag late");
  property p_gbl_zero;
    rd_setup && paddr != OFF_STAT && stat.global_reset_active && $past(stat.global_reset_active)
      |=> prdata == RST_WORD;
  endproperty
  a_gbl_zero: assert property (p_gbl_zero) else $error("register not cleared by global reset");
  property p_sirq;
    stat.global_reset_active && $past(stat.global_reset_active) |-> stat.sirq_continuous;
  endproperty
  a_sirq: assert property (p_sirq) else $error("start frame not continuous in global reset");
  property p_bus_flag;
    (!pins.host_bus_reset_n && ce) [*3] |-> stat.bus_reset_active;
  endproperty
  a_bus_flag: assert property (p_bus_flag) else $error("bus reset flag late");
  // Four cycles, since the synchroniser starts from the reset-asserted level
  property p_bus_free;
    (pins.host_bus_reset_n && ce) [*4] |-> !stat.bus_reset_active;
  endproperty
  a_bus_free: assert property (p_bus_free) else $error("bus reset flag stuck");
  property p_bus_ord;
    rd_setup && paddr >= OFF_ORD0 && paddr < 8'h74 && stat.bus_reset_active
      && $past(stat.bus_reset_active) |=> prdata == RST_WORD;
  endproperty
  a_bus_ord: assert property (p_bus_ord) else $error("scratch kept through bus reset");
  property p_arm_hold;
    (stat.bus_reset_active && !stat.global_reset_active && ce) [*4] |-> $stable(stat.wake_armed);
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("wake arming moved in bus reset");
  property p_unmap;
    psel && penable && paddr >= 8'h74 |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access without error");
  property p_susp;
    (!pins.hw_suspend_n && ce) [*3] ##0 (psel && penable && pwrite) |-> pslverr;
  endproperty
  a_susp: assert property (p_susp) else $error("write accepted in suspend");
  c_armed: cover property (stat.bus_reset_active && |stat.wake_armed);
  c_err: cover property (psel && penable && pslverr);
  c_quiet: cover property (!stat.sirq_continuous);
endmodule // mdrc_chk

bind mdrc_top mdrc_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .pins(pins), .stat(stat));

// *** mdrc_platform.sv ***
/*
  Platform model: power rails and reset pins in power-up order.
  Assumes pclk stands in for the host bus clock and never stops.
*/
`timescale 1ns/10ps
module mdrc_platform
  import mdrc_pkg::*;
#(parameter int HOLD = 5000)
(
  // Clock
  input wire logic pclk,
  // Requests
  input wire logic go,
  input wire logic swap,
  input wire logic bus_req,
  input wire logic susp_req,
  // Rails and pins
  output logic rails_on,
  output logic host_bus_supply,
  output mdrc_pkg::mdrc_pins_t pins,
  output logic done
);
  initial begin
    pins = '0;
    rails_on = 1'b0;
    host_bus_supply = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        pins <= '0;
        done <= 1'b0;
        rails_on <= 1'b0;
        host_bus_supply <= 1'b0;
        repeat (8) @(posedge pclk);
        rails_on <= 1'b1;
        @(posedge pclk);
        if (swap) begin
          pins.global_reset_n <= 1'b1;
          @(posedge pclk);
          host_bus_supply <= 1'b1;
        end else begin
          host_bus_supply <= 1'b1;
          @(posedge pclk);
          pins.global_reset_n <= 1'b1;
        end
        @(posedge pclk);
        pins.hw_suspend_n <= 1'b1;
        // Clock keeps running for the whole hold, as the bus reset release needs
        repeat (HOLD) @(posedge pclk);
        pins.host_bus_reset_n <= 1'b1;
        done <= 1'b1;
      end else if (done) begin
        pins.host_bus_reset_n <= !bus_req;
        pins.hw_suspend_n <= !susp_req;
      end
    end
  end
endmodule // mdrc_platform

// *** testbench.sv ***
/*
  Self-checking bench for mdrc_top driven by the platform model.
  Assumes mdrc_pkg, mdrc_top, the checker and mdrc_platform are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import mdrc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mdrc_pins_t pins;
  mdrc_evt_t evt = '0;
  mdrc_stat_t stat;
  logic go = 1'b0;
  logic swap = 1'b0;
  logic bus_req = 1'b0;
  logic susp_req = 1'b0;
  logic done;
  logic [31:0] q;
  logic [31:0] x;
  int err_total = 0;
  int n_checks = 0;
  always #10 pclk = ~pclk;
  mdrc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .evt(evt), .stat(stat));
  mdrc_platform plat (.pclk(pclk), .go(go), .swap(swap), .bus_req(bus_req), .susp_req(susp_req),
    .rails_on(), .host_bus_supply(), .pins(pins), .done(done));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t error flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ex);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("BAD t=%0t no ready", $time);
      end_of_test();
    end
    q = prdata;
    chk1(pslverr, ex);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ex);
    xfer(1'b0, a, 32'h0, ex);
    chk(q, exp);
  endtask
  task automatic power_up(input logic s);
    int n;
    @(posedge pclk);
    go <= 1'b1;
    swap <= s;
    @(posedge pclk);
    go <= 1'b0;
    // Let the synchronised global reset land before reading mid-sequence
    repeat (3) @(posedge pclk);
    rd(OFF_SUBSYS, RST_WORD, 1'b0);
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      $display("BAD t=%0t power-up hung", $time);
      end_of_test();
    end
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    power_up(1'b0);
    rd(OFF_STAT, 32'h0001_0007, 1'b0);
    $display("test power-up done");
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 8'(4 * i), 32'hA5C3_0F10 + i, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 8'(96 + 4 * i), 32'h1234_0000 + i, 1'b0);
    end
    xfer(1'b1, OFF_SMASK, 32'h0000_000A, 1'b0);
    for (int i = 10; i < 15; i++) begin
      xfer(1'b1, 8'(4 * i), 32'hFFFF_FFFF, 1'b0);
    end
    xfer(1'b1, OFF_PM0, 32'h8000_0103, 1'b0);
    xfer(1'b1, 8'h48, 32'h8000_0003, 1'b0);
    @(posedge pclk);
    evt.sock_evt_set <= 4'h5;
    evt.pme_set <= 5'h01;
    evt.csc_set <= 4'h6;
    @(posedge pclk);
    evt <= '0;
    bus_req <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(OFF_STAT, 32'h0001_0105, 1'b0);
    rd(OFF_ORD0, RST_WORD, 1'b0);
    @(posedge pclk);
    bus_req <= 1'b0;
    repeat (6) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      x = (i == 3) ? (32'hA5C3_0F13 & MSK_SROM) : (i > 5) ? ((32'hA5C3_0F10 + i) & MSK_24) : 32'hA5C3_0F10 + i;
      rd(8'(4 * i), x, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      rd(8'(96 + 4 * i), RST_WORD, 1'b0);
    end
    rd(OFF_SMASK, 32'h0000_000A, 1'b0);
    rd(OFF_SEVT, 32'h0000_0005, 1'b0);
    rd(OFF_SPRES, MSK_SPRES, 1'b0);
    rd(OFF_SCTL, 32'h0000_0070, 1'b0);
    rd(OFF_PWRCTL, 32'h0000_00FC, 1'b0);
    rd(OFF_CSC, 32'h0000_0006, 1'b0);
    rd(OFF_CSCCFG, 32'h0000_000F, 1'b0);
    rd(OFF_PM0, 32'h8000_8100, 1'b0);
    rd(8'h48, RST_WORD, 1'b0);
    rd(OFF_STAT, 32'h0001_0007, 1'b0);
    $display("test bus reset done");
    xfer(1'b1, 8'h4C, 32'h8000_0103, 1'b0);
    xfer(1'b1, 8'h6C, 32'h0BAD_0003, 1'b0);
    xfer(1'b1, 8'h70, 32'h0BAD_0004, 1'b0);
    rd(OFF_STAT, 32'h0001_0807, 1'b0);
    xfer(1'b1, 8'h4C, 32'h8000_0100, 1'b0);
    rd(8'h6C, RST_WORD, 1'b0);
    rd(8'h70, 32'h0BAD_0004, 1'b0);
    rd(8'h4C, 32'h8000_0100, 1'b0);
    rd(OFF_SUBSYS, 32'hA5C3_0F10, 1'b0);
    $display("test power state exit done");
    for (int k = 3; k >= 2; k--) begin
      @(posedge pclk);
      evt.stop_valid <= 1'b1;
      evt.stop_width <= 2'(k);
      @(posedge pclk);
      evt.stop_valid <= 1'b0;
      rd(OFF_STAT, (k == 3) ? 32'h0001_0007 : 32'h0000_0007, 1'b0);
    end
    $display("test stop width done");
    rd(8'h3C, RST_WORD, 1'b1);
    xfer(1'b1, 8'h7C, 32'hFFFF_FFFF, 1'b1);
    ce <= 1'b0;
    xfer(1'b1, 8'h70, 32'hDEAD_0000, 1'b0);
    ce <= 1'b1;
    rd(8'h70, 32'h0BAD_0004, 1'b0);
    susp_req <= 1'b1;
    repeat (5) @(posedge pclk);
    xfer(1'b1, 8'h70, 32'hDEAD_0000, 1'b1);
    rd(8'h70, 32'h0BAD_0004, 1'b0);
    rd(OFF_STAT, 32'h0000_0003, 1'b0);
    susp_req <= 1'b0;
    repeat (5) @(posedge pclk);
    $display("test refusals done");
    power_up(1'b1);
    rd(OFF_SUBSYS, RST_WORD, 1'b0);
    rd(8'h4C, RST_WORD, 1'b0);
    rd(OFF_SMASK, RST_WORD, 1'b0);
    rd(OFF_STAT, 32'h0001_0007, 1'b0);
    $display("test global reset done");
    end_of_test();
  end
endmodule // testbench
